// [hdl/pwr_alert_pkg.sv]
// constants, types and register map of the power status alert logic
package pwr_alert_pkg;
  // time base and documented times
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned T_FILT_US = 50;
  localparam int unsigned T_HOLD_MS = 1;
  localparam int unsigned T_PGTMO_MS = 20;
  localparam int unsigned T_PBCLR_MS = 50;
  localparam int unsigned T_TIMER_S = 1;
  localparam int unsigned T_HRLONG_S = 10;
  localparam int unsigned T_HRSHORT_S = 5;
  // derived cycle counts
  localparam int unsigned FILT_CYC = T_FILT_US * CLK_MHZ;
  localparam int unsigned HOLD_CYC = T_HOLD_MS * CLK_MHZ * 1000;
  localparam int unsigned PGTMO_CYC = T_PGTMO_MS * CLK_MHZ * 1000;
  localparam int unsigned PBCLR_CYC = T_PBCLR_MS * CLK_MHZ * 1000;
  localparam int unsigned TIMER_CYC = T_TIMER_S * CLK_MHZ * 1000000;
  localparam int unsigned HRLONG_CYC = T_HRLONG_S * CLK_MHZ * 1000000;
  localparam int unsigned HRSHORT_CYC = T_HRSHORT_S * CLK_MHZ * 1000000;
  // register sub-addresses
  localparam logic [7:0] OFS_BUCK1 = 8'h01;
  localparam logic [7:0] OFS_AUX = 8'h0b;
  localparam logic [7:0] OFS_CFG = 8'h0e;
  localparam logic [7:0] OFS_EV_MASK = 8'h10;
  localparam logic [7:0] OFS_RAIL_MASK = 8'h11;
  localparam logic [7:0] OFS_EV_STAT = 8'h13;
  localparam logic [7:0] OFS_RAIL_LAT = 8'h15;
  localparam logic [7:0] OFS_RAIL_LIVE = 8'h16;
  localparam logic [7:0] OFS_CLR = 8'h1d;
  localparam logic [7:0] OFS_HR = 8'h1e;
  // reset values and writable bits
  localparam logic [7:0] RAIL_MASK_RST = 8'hef;
  localparam logic [7:0] RAIL_MASK_RW = 8'hef;
  localparam logic [7:0] RAIL_NOMASK = 8'h10;
  localparam logic [7:0] EV_MASK_RST = 8'h00;
  localparam logic [7:0] EV_MASK_RW = 8'h7d;
  localparam logic [7:0] EV_STICKY = 8'h7e;
  localparam logic [7:0] EV_ALERT = 8'h7f;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] BUCK1_RST = 8'h00;
  localparam logic [4:0] AUX_RST = 5'h00;
  // field positions
  localparam int unsigned CFG_HR_SHORT = 6;
  localparam int unsigned BUCK1_EN = 7;
  localparam int unsigned EV_PGTMO = 2;
  localparam int unsigned EV_HR = 1;
  // register port request
  typedef struct packed {
    logic wr;
    logic cmd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // fourth ldo control fields, bit 4 down to bit 0
  typedef struct packed {
    logic [1:0] vsel;
    logic en;
    logic low_only;
    logic keep_alive;
  } aux_ldo_t;
  // monitor inputs from outside the clock domain
  typedef struct packed {
    logic [7:0] rail_low;
    logic [7:0] rail_up;
    logic uv_warn;
    logic uv_fault;
    logic ot_warn;
    logic ot_fault;
    logic ldo1_low;
    logic buck1_pin;
    logic power_up;
    logic aux_below300;
    logic pb_n;
  } sense_t;
  localparam sense_t SENSE_RST = sense_t'(25'h0000001);
  // supervisory states
  typedef enum logic [2:0] {
    S_RUN, S_HRT, S_SBT, S_HOLD, S_STBY
  } state_t;
endpackage

// [hdl/power_status_alert_logic.sv]
// supervisory rail status, alert and reset logic of the power manager
// Operation
// - rails ok output low whenever every regulator is disabled.
// - release rails ok only when all enabled rails are above 94%.
// - pull rails ok low after an enabled rail stays low over 50us.
// - rail low beyond 20ms pulls alert low, sets event bit 2.
// - keep rails ok low 1ms after the rail low condition ends.
// - latched rail status holds lows 1ms; live status only while low.
// - rail status readable; bits 0-3 bucks, 4-7 ldos, 0 means low.
// - rail mask bits decide which rails other than rail 4 may pull rails ok low.
// - undervoltage, overtemperature, rail timeout latch the alert output low.
// - alert released by clear command or pushbutton low 50ms.
// - event status bit map: pushbutton, hard reset, timeout, uv, ot.
// - event mask 1 blocks alert but the event is still recorded.
// - masked faults and hard resets still move the state controller.
// - clear command clears latched event bits and releases alert.
// - hard reset and fault shutdown keep alert and event status.
// - system reset low while ldo1 low or in hard reset timer.
// - hard reset by command or pushbutton held 10s or 5s.
// - hard reset returns all command register bits to defaults.
// - hard reset passes a 1s timer state then reset hold.
// - faults pass a 1s standby timer state then standby.
// - fourth ldo control: keep alive, low-start, enable, voltage.
// - buck1 pin or control bit 7 enables termination ref and buck1.
`timescale 1ns/1ps
module power_status_alert_logic #(
  parameter int unsigned HOLD_CYC = pwr_alert_pkg::HOLD_CYC,
  parameter int unsigned PGTMO_CYC = pwr_alert_pkg::PGTMO_CYC,
  parameter int unsigned PBCLR_CYC = pwr_alert_pkg::PBCLR_CYC,
  parameter int unsigned TIMER_CYC = pwr_alert_pkg::TIMER_CYC,
  parameter int unsigned HRLONG_CYC = pwr_alert_pkg::HRLONG_CYC,
  parameter int unsigned HRSHORT_CYC = pwr_alert_pkg::HRSHORT_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register port from the serial engine
  input wire pwr_alert_pkg::reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // regulator enables and asynchronous monitors
  input wire logic [7:0] rail_en_i,
  input wire pwr_alert_pkg::sense_t sense_i,
  // open-drain rails ok pin
  input wire logic rails_ok_out_i,
  output logic rails_ok_out_o,
  output logic rails_ok_oe_n_o,
  // open-drain alert pin
  input wire logic alert_n_i,
  output logic alert_n_o,
  output logic alert_oe_n_o,
  // open-drain system reset pin
  input wire logic system_reset_out_n_i,
  output logic system_reset_out_n_o,
  output logic system_reset_oe_n_o,
  // state and regulator controls
  output logic standby_o,
  output logic reset_hold_o,
  output logic down_seq_o,
  output logic [7:0] general_config_o,
  output logic buck1_en_o,
  output logic termination_ref_out_o,
  output logic aux_ldo_en_o,
  output logic [1:0] aux_ldo_vsel_o
);
  localparam int FW = $clog2(pwr_alert_pkg::FILT_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // write with a data byte to a sub-address
  function automatic logic wr_hit(input pwr_alert_pkg::reg_req_t r,
                                  input logic [7:0] a);
    return r.wr && r.addr == a;
  endfunction

  // sub-address only command, a data write is taken as well
  function automatic logic cmd_hit(input pwr_alert_pkg::reg_req_t r,
                                   input logic [7:0] a);
    return (r.cmd || r.wr) && r.addr == a;
  endfunction

  // saturating increment, so long counters never wrap
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hffffffff) ? v : v + 32'h00000001;
  endfunction

  pwr_alert_pkg::sense_t s1_q, s_q;
  pwr_alert_pkg::state_t st_q, st_d;
  pwr_alert_pkg::aux_ldo_t aux_q;
  logic [7:0] rail_mask_q, ev_mask_q, cfg_q, buck1_q, ev_q;
  logic [FW-1:0] flt_cnt_q [8];
  logic [HW-1:0] lat_cnt_q [8];
  logic [HW-1:0] hold_q;
  logic [7:0] low_now, flt, lat, live, ev_set, rd_d, rdata_q;
  logic [31:0] tmo_q, pb_q, st_cnt_q;
  logic pg_flt, up_miss, release_ok, pg_drive_q, tmo_p, pb_low;
  logic pb_press, pb_clr_p, hr_pb_p, clr_cmd, hr_req, fault;
  logic hr_start, tdone, alert_q, alert_set, alert_clr;
  logic rst_drive_q, buck1_en_q, aux_on_q;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // two flops for every sense_i monitor input
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= pwr_alert_pkg::SENSE_RST;
      s_q <= pwr_alert_pkg::SENSE_RST;
    end else begin
      s1_q <= sense_i;
      s_q <= s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command registers

  // host writes; a hard reset restores every default
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rail_mask_q <= pwr_alert_pkg::RAIL_MASK_RST;
      ev_mask_q <= pwr_alert_pkg::EV_MASK_RST;
      cfg_q <= pwr_alert_pkg::CFG_RST;
      buck1_q <= pwr_alert_pkg::BUCK1_RST;
      aux_q <= pwr_alert_pkg::AUX_RST;
    end else if (hr_start) begin
      rail_mask_q <= pwr_alert_pkg::RAIL_MASK_RST;
      ev_mask_q <= pwr_alert_pkg::EV_MASK_RST;
      cfg_q <= pwr_alert_pkg::CFG_RST;
      buck1_q <= pwr_alert_pkg::BUCK1_RST;
      aux_q <= pwr_alert_pkg::AUX_RST;
    end else begin
      if (wr_hit(reg_req_i, pwr_alert_pkg::OFS_RAIL_MASK)) begin
        rail_mask_q <= reg_req_i.wdata & pwr_alert_pkg::RAIL_MASK_RW;
      end
      if (wr_hit(reg_req_i, pwr_alert_pkg::OFS_EV_MASK)) begin
        ev_mask_q <= reg_req_i.wdata & pwr_alert_pkg::EV_MASK_RW;
      end
      if (wr_hit(reg_req_i, pwr_alert_pkg::OFS_CFG)) begin
        cfg_q <= reg_req_i.wdata;
      end
      if (wr_hit(reg_req_i, pwr_alert_pkg::OFS_BUCK1)) begin
        buck1_q <= reg_req_i.wdata;
      end
      if (wr_hit(reg_req_i, pwr_alert_pkg::OFS_AUX)) begin
        aux_q <= reg_req_i.wdata[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rail low filters and status

  assign low_now = rail_en_i & s_q.rail_low;

  // glitch filter per rail, restarted by any recovery
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 8; i++) flt_cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!low_now[i]) begin
          flt_cnt_q[i] <= '0;
        end else if (flt_cnt_q[i] != FW'(pwr_alert_pkg::FILT_CYC)) begin
          flt_cnt_q[i] <= flt_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  // latched status keeps each low for the hold time
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 8; i++) lat_cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (low_now[i]) begin
          lat_cnt_q[i] <= HW'(HOLD_CYC);
        end else if (lat_cnt_q[i] != '0) begin
          lat_cnt_q[i] <= lat_cnt_q[i] - 1'b1;
        end
      end
    end
  end

  // filtered flags and status views, zero means low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      flt[i] = flt_cnt_q[i] == FW'(pwr_alert_pkg::FILT_CYC);
      lat[i] = !(low_now[i] || lat_cnt_q[i] != '0);
    end
  end
  assign live = ~low_now;
  // masking acts on the pin only, never on the status
  assign pg_flt = |(flt & (rail_mask_q | pwr_alert_pkg::RAIL_NOMASK));
  assign up_miss = |(rail_en_i & ~s_q.rail_up);
  assign release_ok = (rail_en_i != 8'h00) && !up_miss && !pg_flt
                      && hold_q == '0;

  ////////////////////////////////////////////////////////////////////////
  // rails ok pin

  // extension after the low condition, then the pin driver
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_q <= '0;
      pg_drive_q <= 1'b1;
    end else begin
      if (pg_flt) begin
        hold_q <= HW'(HOLD_CYC);
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
      end
      pg_drive_q <= !release_ok;
    end
  end
  assign rails_ok_out_o = 1'b0;
  assign rails_ok_oe_n_o = !pg_drive_q;

  ////////////////////////////////////////////////////////////////////////
  // persistence, pushbutton and state timers

  // all long counters restart when their condition goes away
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmo_q <= '0;
      pb_q <= '0;
      st_cnt_q <= '0;
    end else begin
      tmo_q <= (|low_now) ? sat_inc(tmo_q) : 32'h00000000;
      pb_q <= pb_low ? sat_inc(pb_q) : 32'h00000000;
      st_cnt_q <= (st_d != st_q) ? 32'h00000000 : sat_inc(st_cnt_q);
    end
  end

  assign pb_low = !s_q.pb_n;
  assign pb_press = pb_low && pb_q == 32'h00000000;
  assign tmo_p = (|low_now) && tmo_q == 32'(PGTMO_CYC - 1);
  assign pb_clr_p = pb_low && pb_q == 32'(PBCLR_CYC - 1);
  assign hr_pb_p = pb_low && pb_q == (cfg_q[pwr_alert_pkg::CFG_HR_SHORT]
                   ? 32'(HRSHORT_CYC - 1) : 32'(HRLONG_CYC - 1));
  assign tdone = st_cnt_q == 32'(TIMER_CYC - 1);
  // sub-address only commands from the host
  assign clr_cmd = cmd_hit(reg_req_i, pwr_alert_pkg::OFS_CLR);
  assign hr_req = cmd_hit(reg_req_i, pwr_alert_pkg::OFS_HR) || hr_pb_p;
  assign fault = s_q.uv_fault || s_q.ot_fault;
  assign hr_start = st_q == pwr_alert_pkg::S_RUN && !fault && hr_req;

  ////////////////////////////////////////////////////////////////////////
  // state controller

  // masks never stop faults or hard resets from moving the state
  always_comb begin
    st_d = st_q;
    case (st_q)
      pwr_alert_pkg::S_RUN: begin
        if (fault) st_d = pwr_alert_pkg::S_SBT;
        else if (hr_req) st_d = pwr_alert_pkg::S_HRT;
      end
      pwr_alert_pkg::S_HRT: begin
        if (tdone) st_d = pwr_alert_pkg::S_HOLD;
      end
      pwr_alert_pkg::S_SBT: begin
        if (tdone) st_d = pwr_alert_pkg::S_STBY;
      end
      pwr_alert_pkg::S_HOLD, pwr_alert_pkg::S_STBY: begin
        if (s_q.power_up && !fault) st_d = pwr_alert_pkg::S_RUN;
      end
      default: st_d = pwr_alert_pkg::S_RUN;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) st_q <= pwr_alert_pkg::S_RUN;
    else st_q <= st_d;
  end
  assign standby_o = st_q == pwr_alert_pkg::S_STBY;
  assign reset_hold_o = st_q == pwr_alert_pkg::S_HOLD;
  assign down_seq_o = st_q == pwr_alert_pkg::S_SBT;

  ////////////////////////////////////////////////////////////////////////
  // event status and alert

  assign ev_set = {1'b0, s_q.ot_fault, s_q.ot_warn, s_q.uv_fault,
                   s_q.uv_warn, tmo_p, hr_start, pb_press};
  assign alert_set = |(ev_set & ~ev_mask_q & pwr_alert_pkg::EV_ALERT);
  assign alert_clr = clr_cmd || pb_clr_p;

  // sticky bits, a set in the clear cycle wins; nothing else clears
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_q <= 8'h00;
      alert_q <= 1'b0;
    end else begin
      ev_q <= ((clr_cmd ? 8'h00 : ev_q) | ev_set)
              & pwr_alert_pkg::EV_STICKY;
      alert_q <= (alert_q && !alert_clr) || alert_set;
    end
  end
  assign alert_n_o = 1'b0;
  assign alert_oe_n_o = !alert_q;

  ////////////////////////////////////////////////////////////////////////
  // reset pin and regulator enables

  // reset pin, buck1 pair and fourth ldo enable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_drive_q <= 1'b0;
      buck1_en_q <= 1'b0;
      aux_on_q <= 1'b0;
    end else begin
      rst_drive_q <= s_q.ldo1_low || st_q == pwr_alert_pkg::S_HRT;
      buck1_en_q <= s_q.buck1_pin || buck1_q[pwr_alert_pkg::BUCK1_EN];
      if (!aux_q.en || (standby_o && !aux_q.keep_alive)) begin
        aux_on_q <= 1'b0;
      end else if (!aux_q.low_only || s_q.aux_below300) begin
        aux_on_q <= 1'b1;
      end
    end
  end
  assign system_reset_out_n_o = 1'b0;
  assign system_reset_oe_n_o = !rst_drive_q;
  assign buck1_en_o = buck1_en_q;
  assign termination_ref_out_o = buck1_en_q;
  assign aux_ldo_en_o = aux_on_q;
  assign aux_ldo_vsel_o = aux_q.vsel;
  assign general_config_o = cfg_q;

  ////////////////////////////////////////////////////////////////////////
  // read port

  // read decode, unmapped addresses read zero
  always_comb begin
    rd_d = 8'h00;
    if (reg_req_i.addr == pwr_alert_pkg::OFS_RAIL_LAT) rd_d = lat;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_RAIL_LIVE) rd_d = live;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_EV_STAT) rd_d = ev_q | {7'h00, pb_low};
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_EV_MASK) rd_d = ev_mask_q;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_RAIL_MASK) rd_d = rail_mask_q;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_CFG) rd_d = cfg_q;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_BUCK1) rd_d = buck1_q;
    else if (reg_req_i.addr == pwr_alert_pkg::OFS_AUX) rd_d = {3'h0, aux_q};
  end

  // registered read data
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) rdata_q <= 8'h00;
    else rdata_q <= rd_d;
  end
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_PG_ALL_OFF: assert property (rail_en_i == 8'h00 |=> !rails_ok_oe_n_o)
    else $error("rails ok released with all rails off");
  AST_PG_UP: assert property (rails_ok_oe_n_o |-> !$past(up_miss))
    else $error("rails ok released with an enabled rail not up");
  AST_FILT_RESTART: assert property (!low_now[0] |=> !flt[0])
    else $error("filter flag survived a recovery");
  AST_PG_TMO: assert property (tmo_p && !ev_mask_q[2] |=> ev_q[2] && !alert_oe_n_o)
    else $error("rail timeout not reported");
  AST_PG_HOLD: assert property ($fell(pg_flt) |=> !rails_ok_oe_n_o [*4])
    else $error("rails ok released without hold time");
  AST_CLR: assert property (clr_cmd && !alert_set && (ev_set & 8'h7e) == 8'h00
    |=> ev_q == 8'h00 && alert_oe_n_o)
    else $error("clear command did not clear");
  AST_HR_KEEP: assert property (hr_start && !clr_cmd |=> ev_q[1] && !alert_oe_n_o)
    else $error("hard reset lost its event");
  AST_RST_PIN: assert property (st_q == pwr_alert_pkg::S_HRT |=> !system_reset_oe_n_o)
    else $error("system reset not driven in hard reset timer");
  AST_HR_DEFAULTS: assert property (hr_start |=> ev_mask_q == 8'h00 && cfg_q == 8'h00)
    else $error("hard reset did not restore defaults");
  AST_HR_SEQ: assert property (st_q == pwr_alert_pkg::S_HRT && tdone
    |=> st_q == pwr_alert_pkg::S_HOLD)
    else $error("hard reset timer did not reach reset hold");
  AST_BUCK1: assert property (s_q.buck1_pin |=> buck1_en_o && termination_ref_out_o)
    else $error("buck1 pin did not enable both outputs");

  COV_HR: cover property (st_q == pwr_alert_pkg::S_HRT ##1 st_q == pwr_alert_pkg::S_HOLD);
  COV_TMO: cover property (tmo_p ##1 !alert_oe_n_o);
  COV_CLR: cover property (!alert_oe_n_o ##1 alert_clr ##1 alert_oe_n_o);
endmodule

// [tb/host_pins_model.sv]
// host side of the three open-drain status pins, with board pull-ups
`timescale 1ns/1ps
module host_pins_model (
  // pin drive from the device
  input wire logic ok_data_i,
  input wire logic ok_oe_n_i,
  input wire logic alert_data_i,
  input wire logic alert_oe_n_i,
  input wire logic rst_data_i,
  input wire logic rst_oe_n_i,
  // resolved pin levels seen by the host
  output logic ok_pin_o,
  output logic alert_pin_o,
  output logic rst_pin_o
);
  // a released pin floats up to the pull-up level
  assign ok_pin_o = ok_oe_n_i ? 1'b1 : ok_data_i;
  assign alert_pin_o = alert_oe_n_i ? 1'b1 : alert_data_i;
  assign rst_pin_o = rst_oe_n_i ? 1'b1 : rst_data_i;
endmodule

// [tb/tb_power_status_alert_logic.sv]
// self-checking bench of the power status alert logic
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_power_status_alert_logic;
  localparam logic [7:0] SR = 8'h01;
  localparam logic [7:0] AL = 8'h02;
  localparam logic [7:0] PG = 8'h04;
  localparam logic [7:0] TR = 8'h08;
  localparam logic [7:0] AX = 8'h10;
  localparam logic [7:0] DS = 8'h20;
  localparam logic [7:0] HO = 8'h40;
  localparam logic [7:0] SB = 8'h80;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  pwr_alert_pkg::reg_req_t req = '0;
  pwr_alert_pkg::sense_t sn = pwr_alert_pkg::SENSE_RST;
  logic [7:0] rail_en = 8'h00;
  logic [7:0] rdata, pins, misc, msk, exp_v, rnd;
  logic ok_o, ok_oe, al_o, al_oe, rs_o, rs_oe, ok_pin, al_pin, rs_pin;
  logic sb, ho, ds, b1, tr, ax, look = 1'b0;
  logic [1:0] sel = 2'd0;
  logic [7:0] cfg;
  logic [1:0] vsel;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int n_checks = 0;

  power_status_alert_logic #(.HOLD_CYC(8), .PGTMO_CYC(40),
    .PBCLR_CYC(30), .TIMER_CYC(20), .HRLONG_CYC(60), .HRSHORT_CYC(50))
  u_power_status_alert_logic (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .rail_en_i(rail_en),
    .sense_i(sn), .rails_ok_out_i(ok_pin), .rails_ok_out_o(ok_o),
    .rails_ok_oe_n_o(ok_oe), .alert_n_i(al_pin), .alert_n_o(al_o),
    .alert_oe_n_o(al_oe), .system_reset_out_n_i(rs_pin),
    .system_reset_out_n_o(rs_o), .system_reset_oe_n_o(rs_oe),
    .standby_o(sb), .reset_hold_o(ho), .down_seq_o(ds),
    .general_config_o(cfg), .buck1_en_o(b1), .termination_ref_out_o(tr),
    .aux_ldo_en_o(ax), .aux_ldo_vsel_o(vsel));

  host_pins_model u_host_pins_model (.ok_data_i(ok_o), .ok_oe_n_i(ok_oe),
    .alert_data_i(al_o), .alert_oe_n_i(al_oe), .rst_data_i(rs_o),
    .rst_oe_n_i(rs_oe), .ok_pin_o(ok_pin), .alert_pin_o(al_pin),
    .rst_pin_o(rs_pin));

  ////////////////////////////////////////////////////////////////////////
  // clock and observed pin vector
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  assign pins = {sb, ho, ds, ax, tr, ok_oe, al_oe, rs_oe};
  // config, ldo voltage, buck1 enable and the resolved pin levels
  assign misc = {cfg[6], vsel, b1, ok_pin, al_pin, rs_pin, cfg[0]};

  // monitor takes the oldest expectation whenever a result is shown
  always @(negedge sys_clk_i) begin
    if (look) begin
      exp_v = exp_q.pop_front();
      `CHK(((sel == 2'd2) ? misc : (sel == 2'd1) ? pins : rdata) & msk, exp_v)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus and check tasks, all entered and left 10 ns after a rising edge
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #10;
  endtask
  task automatic note(input logic [1:0] s, input logic [7:0] m, e);
    exp_q.push_back(e & m);
    sel = s;
    msk = m;
    look = 1'b1;
    @(negedge sys_clk_i);
    #1 look = 1'b0;
    tick();
  endtask
  task automatic pin(input logic [7:0] m, e);
    note(2'd1, m, e);
  endtask
  task automatic lvl(input logic [7:0] m, e);
    note(2'd2, m, e);
  endtask
  task automatic rd(input logic [7:0] a, e);
    req.addr = a;
    tick();
    note(2'd0, 8'hff, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick();
    req.wr = 1'b0;
    tick();
  endtask
  // commands carry a sub-address only, no data byte
  task automatic cmd(input logic [7:0] a);
    req.cmd = 1'b1;
    req.addr = a;
    tick();
    req.cmd = 1'b0;
    tick();
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog at 30000 cycles, far beyond the roughly 900 cycles of the run
  initial begin
    #3_000_000;
    n_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #10 rstn_i = 1'b1;
    tick(3);
    pin(PG | AL | SR, SR | AL);
    sn.ldo1_low = 1'b1;
    tick(4);
    pin(SR, 8'h00);
    lvl(8'h02, 8'h00);
    sn.ldo1_low = 1'b0;
    tick(4);
    pin(SR, SR);
    rd(pwr_alert_pkg::OFS_RAIL_MASK, 8'hef);
    rd(pwr_alert_pkg::OFS_AUX, 8'h00);
    rd(8'h05, 8'h00);
    rnd = 8'd19;
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(pwr_alert_pkg::OFS_EV_MASK, rnd);
      rd(pwr_alert_pkg::OFS_EV_MASK, rnd & 8'h7d);
    end
    wr(pwr_alert_pkg::OFS_EV_MASK, 8'h00);
    rail_en = 8'h01;
    sn.rail_up = 8'h01;
    tick(6);
    pin(PG, PG);
    sn.rail_low = 8'h01;
    tick(8);
    rd(pwr_alert_pkg::OFS_RAIL_LIVE, 8'hfe);
    tick(20);
    pin(PG | AL, PG | AL);
    sn.rail_low = 8'h00;
    tick(3);
    rd(pwr_alert_pkg::OFS_RAIL_LAT, 8'hfe);
    tick(20);
    rd(pwr_alert_pkg::OFS_RAIL_LAT, 8'hff);
    cmd(pwr_alert_pkg::OFS_CLR);
    sn.rail_low = 8'h01;
    tick(520);
    pin(PG | AL, 8'h00);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h04);
    sn.rail_low = 8'h00;
    tick(5);
    pin(PG, 8'h00);
    tick(20);
    pin(PG, PG);
    cmd(pwr_alert_pkg::OFS_CLR);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h00);
    pin(AL, AL);
    wr(pwr_alert_pkg::OFS_EV_MASK, 8'h08);
    sn.uv_warn = 1'b1;
    tick(5);
    sn.uv_warn = 1'b0;
    tick(3);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h08);
    pin(AL, AL);
    wr(pwr_alert_pkg::OFS_EV_MASK, 8'h00);
    sn.ot_warn = 1'b1;
    tick(5);
    sn.ot_warn = 1'b0;
    tick(3);
    pin(AL, 8'h00);
    sn.pb_n = 1'b0;
    tick(40);
    pin(AL, AL);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h29);
    sn.pb_n = 1'b1;
    tick(4);
    cmd(pwr_alert_pkg::OFS_CLR);
    wr(pwr_alert_pkg::OFS_AUX, 8'h1e);
    rd(pwr_alert_pkg::OFS_AUX, 8'h1e);
    pin(AX, 8'h00);
    lvl(8'h60, 8'h60);
    sn.aux_below300 = 1'b1;
    tick(4);
    pin(AX, AX);
    cmd(pwr_alert_pkg::OFS_HR);
    pin(SR | AL, 8'h00);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h02);
    rd(pwr_alert_pkg::OFS_AUX, 8'h00);
    tick(20);
    pin(HO | AL, HO);
    sn.power_up = 1'b1;
    tick(5);
    sn.power_up = 1'b0;
    wr(pwr_alert_pkg::OFS_EV_MASK, 8'h50);
    sn.ot_fault = 1'b1;
    sn.uv_fault = 1'b1;
    tick(5);
    pin(DS | SB, DS);
    tick(25);
    pin(DS | SB | AL, SB);
    rd(pwr_alert_pkg::OFS_EV_STAT, 8'h52);
    sn.ot_fault = 1'b0;
    sn.uv_fault = 1'b0;
    sn.power_up = 1'b1;
    tick(5);
    sn.power_up = 1'b0;
    sn.buck1_pin = 1'b1;
    tick(5);
    pin(TR, TR);
    lvl(8'h1e, 8'h1a);
    wr(pwr_alert_pkg::OFS_CFG, 8'h40);
    lvl(8'h80, 8'h80);
    sn.pb_n = 1'b0;
    tick(55);
    pin(SR, 8'h00);
    rd(pwr_alert_pkg::OFS_CFG, 8'h00);
    give_verdict();
  end
endmodule
